/* File: hdl/rfdf_pkg.sv */
// Shared constants and types of the datagram frame control block
package rfdf_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BUF_FIRST = 8'h20;
  localparam logic [7:0] IDX_BUF_LAST = 8'h2F;
  localparam logic [7:0] IDX_OUTPUT_MODE = 8'h30;
  localparam logic [7:0] IDX_FRAME_BIT_LENGTH = 8'h31;
  localparam logic [7:0] IDX_TRANSMIT_START = 8'h32;
  localparam logic [7:0] IDX_FRAME_COUNT = 8'h33;
  localparam logic [7:0] IDX_BASE_TIMER = 8'h34;
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h37;
  localparam logic [7:0] IDX_BANK_FIRST = 8'h38;
  localparam logic [7:0] IDX_BANK_LAST = 8'h3B;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TX_SEND_BIT = 7;
  localparam int TX_PAGE_BIT = 6;
  localparam int TX_EOM_BIT = 5;
  localparam int CFG_DATA_BIT = 7;
  localparam int CFG_INTERFRAME_POWER_DOWN_BIT = 6;
  localparam int CFG_INITIAL_SPACE_ENABLE_BIT = 5;
  localparam int CFG_INTERFRAME_INTERRUPT_DELAY_BIT = 4;
  localparam int STAT_FLAG_BIT = 7;
  localparam int STAT_ACK_BIT = 4;
  localparam int STAT_IEN_BIT = 3;
  localparam int STAT_MRST_BIT = 0;
  localparam logic [1:0] MODE_DIRECT = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int BUF_BYTES = 32;
  localparam int BANK_REGS = 8;
  localparam logic [1:0] EOM_BIT_TIMES = 2'h2;
  localparam logic [7:0] RESTART_LEAD_MS = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_TICK_NS = 1000000;
  localparam int MS_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int BIT_CYCLES = 2080;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INIT,
    ST_FRAME,
    ST_EOM,
    ST_GAP,
    ST_TAIL
  } rfdf_state_t;

endpackage

/* File: hdl/rfdf_buf_if.sv */
// Connection between the frame controller and its transmit buffer
`timescale 1ns/100ps
interface rfdf_buf_if;
  logic wr_en;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] bus_raddr;
  logic [7:0] bus_rdata;
  logic [4:0] tx_raddr;
  logic [7:0] tx_rdata;

  modport ctrl (output wr_en, output waddr, output wdata, output bus_raddr, output tx_raddr,
    input bus_rdata, input tx_rdata);
  modport mem (input wr_en, input waddr, input wdata, input bus_raddr, input tx_raddr,
    output bus_rdata, output tx_rdata);
endinterface

/* File: hdl/rfdf_buffer.sv */
// Transmit data buffer with one write port and two registered read ports
`timescale 1ns/100ps
module rfdf_buffer
  import rfdf_pkg::*;
#(
  parameter int DEPTH = BUF_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  rfdf_buf_if.mem bus
);

  // Contents survive both resets on purpose
  logic [7:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (bus.wr_en) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.bus_rdata <= REG_RESET;
      bus.tx_rdata <= REG_RESET;
    end else begin
      bus.bus_rdata <= mem[bus.bus_raddr];
      bus.tx_rdata <= mem[bus.tx_raddr];
    end
  end

endmodule

/* File: hdl/rfdf_tick.sv */
// Restartable divider giving a one-cycle enable pulse every CYC clocks
`timescale 1ns/100ps
module rfdf_tick #(
  parameter int CYC = 20000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  output logic tick
);

  logic [31:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (clr) begin
      // Starting at one puts the first tick exactly CYC clocks after release
      count <= 32'h1;
      tick <= 1'b0;
    end else if (count == 32'(CYC - 1)) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule

/* File: hdl/rfdf_top.sv */
// Datagram frame control: APB registers, frame sequencer and RF stage control
`timescale 1ns/100ps
module rfdf_top
  import rfdf_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int BIT_TICK_CYCLES = BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rf_data_out,
  output logic pa_enable,
  output logic osc_enable,
  output logic completion_irq
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [1:0] output_mode;
  logic [7:0] frame_length_field;
  logic send;
  logic buffer_page_select;
  logic end_of_message_pad;
  logic [7:0] frame_count_and_spacing_control;
  logic [7:0] base_timer_field;
  logic completion_flag;
  logic completion_interrupt_enable;
  logic rf_module_reset;
  logic [7:0] bank [BANK_REGS];

  rfdf_state_t state;
  logic [8:0] bit_cnt;
  logic [3:0] frame_cnt;
  logic [1:0] eom_cnt;
  logic [7:0] ms_left;
  logic tx_bit;
  logic done;

  logic [3:0] frame_count_field;
  logic direct_data;
  logic interframe_power_down;
  logic initial_space_enable;
  logic interframe_interrupt_delay;

  assign direct_data = frame_count_and_spacing_control[CFG_DATA_BIT];
  assign interframe_power_down = frame_count_and_spacing_control[CFG_INTERFRAME_POWER_DOWN_BIT];
  assign initial_space_enable = frame_count_and_spacing_control[CFG_INITIAL_SPACE_ENABLE_BIT];
  assign interframe_interrupt_delay = frame_count_and_spacing_control[CFG_INTERFRAME_INTERRUPT_DELAY_BIT];
  assign frame_count_field = frame_count_and_spacing_control[3:0];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic addr_ok;
  logic is_buf;
  logic is_bank;
  logic mapped;
  logic wr;
  logic [7:0] wbyte;
  logic [2:0] bank_sel;

  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign is_buf = (idx >= IDX_BUF_FIRST) && (idx <= IDX_BUF_LAST);
  assign is_bank = (idx >= IDX_BANK_FIRST) && (idx <= IDX_BANK_LAST);
  assign bank_sel = {buffer_page_select, idx[1:0]};
  assign mapped = addr_ok && (is_buf || is_bank || idx == IDX_OUTPUT_MODE || idx == IDX_FRAME_BIT_LENGTH
    || idx == IDX_TRANSMIT_START || idx == IDX_FRAME_COUNT || idx == IDX_BASE_TIMER
    || idx == IDX_STATUS_CONTROL);
  assign wr = psel && penable && pwrite && mapped;
  assign wbyte = pwdata[7:0];
  // Zero wait states: buffer read data is registered during the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  rfdf_buf_if buf_bus ();

  assign buf_bus.wr_en = wr && is_buf;
  assign buf_bus.waddr = {buffer_page_select, idx[3:0]};
  assign buf_bus.wdata = wbyte;
  assign buf_bus.bus_raddr = {buffer_page_select, idx[3:0]};
  // Byte 0 is fetched ahead while the last bit of a frame is out
  assign buf_bus.tx_raddr = (bit_cnt == {1'b0, frame_length_field} + 9'h1) ? 5'h0 : bit_cnt[7:3];

  rfdf_buffer #(
    .DEPTH(BUF_BYTES)
  ) u_buffer (
    .pclk(pclk),
    .presetn(presetn),
    .bus(buf_bus.mem)
  );

  // ----------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------
  logic ms_tick;
  logic bit_tick;
  logic ms_clr;
  logic bit_clr;

  // Restarting on each wait keeps every interval a whole number of ms
  assign ms_clr = !(state == ST_INIT || state == ST_GAP || state == ST_TAIL);
  assign bit_clr = !(state == ST_FRAME || state == ST_EOM);

  rfdf_tick #(
    .CYC(MS_TICK_CYCLES)
  ) u_ms_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clr(ms_clr),
    .tick(ms_tick)
  );

  rfdf_tick #(
    .CYC(BIT_TICK_CYCLES)
  ) u_bit_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clr(bit_clr),
    .tick(bit_tick)
  );

  // ----------------------------------------------------------------
  // Module reset pulse
  // ----------------------------------------------------------------
  // One-cycle pulse from software; power-on is covered by presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_module_reset <= 1'b0;
    end else begin
      rf_module_reset <= wr && (idx == IDX_STATUS_CONTROL) && wbyte[STAT_MRST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_length_field <= REG_RESET;
      end_of_message_pad <= 1'b0;
      frame_count_and_spacing_control <= REG_RESET;
      base_timer_field <= REG_RESET;
      output_mode <= 2'h0;
      completion_interrupt_enable <= 1'b0;
    end else if (rf_module_reset) begin
      frame_length_field <= REG_RESET;
      end_of_message_pad <= 1'b0;
      frame_count_and_spacing_control <= REG_RESET;
      base_timer_field <= REG_RESET;
      output_mode <= 2'h0;
      completion_interrupt_enable <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_FRAME_BIT_LENGTH: frame_length_field <= wbyte;
        IDX_TRANSMIT_START: end_of_message_pad <= wbyte[TX_EOM_BIT];
        IDX_FRAME_COUNT: frame_count_and_spacing_control <= wbyte;
        IDX_BASE_TIMER: base_timer_field <= wbyte;
        IDX_OUTPUT_MODE: output_mode <= wbyte[1:0];
        IDX_STATUS_CONTROL: completion_interrupt_enable <= wbyte[STAT_IEN_BIT];
        default: ;
      endcase
    end
  end

  // Page select ignores the module reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_page_select <= 1'b0;
    end else if (wr && idx == IDX_TRANSMIT_START) begin
      buffer_page_select <= wbyte[TX_PAGE_BIT];
    end
  end

  // A software write beats the hardware clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send <= 1'b0;
    end else if (rf_module_reset) begin
      send <= 1'b0;
    end else if (wr && idx == IDX_TRANSMIT_START) begin
      send <= wbyte[TX_SEND_BIT];
    end else if (done) begin
      send <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BANK_REGS; i++) begin
        bank[i] <= REG_RESET;
      end
    end else if (rf_module_reset) begin
      for (int i = 0; i < BANK_REGS; i++) begin
        bank[i] <= REG_RESET;
      end
    end else if (wr && is_bank) begin
      bank[bank_sel] <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Completion flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_flag <= 1'b0;
    end else if (rf_module_reset) begin
      completion_flag <= 1'b0;
    end else if (done) begin
      completion_flag <= 1'b1;
    end else if (wr && idx == IDX_STATUS_CONTROL && wbyte[STAT_ACK_BIT]) begin
      completion_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_irq <= 1'b0;
    end else begin
      completion_irq <= completion_flag && completion_interrupt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  logic abort;
  logic last_frame;
  logic frame_end;

  assign abort = wr && idx == IDX_TRANSMIT_START && !wbyte[TX_SEND_BIT];
  assign last_frame = (frame_cnt == frame_count_field);
  assign frame_end = bit_tick && (bit_cnt == {1'b0, frame_length_field} + 9'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      bit_cnt <= 9'h0;
      frame_cnt <= 4'h0;
      eom_cnt <= 2'h0;
      ms_left <= REG_RESET;
      tx_bit <= 1'b0;
      done <= 1'b0;
    end else if (rf_module_reset || abort) begin
      state <= ST_IDLE;
      bit_cnt <= 9'h0;
      frame_cnt <= 4'h0;
      tx_bit <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          bit_cnt <= 9'h0;
          frame_cnt <= 4'h0;
          tx_bit <= 1'b0;
          if (send && !done) begin
            if (frame_length_field == REG_RESET) begin
              done <= 1'b1;
            end else if (initial_space_enable && base_timer_field != REG_RESET) begin
              state <= ST_INIT;
              ms_left <= base_timer_field;
            end else begin
              state <= ST_FRAME;
              bit_cnt <= 9'h1;
              tx_bit <= buf_bus.tx_rdata[7];
            end
          end
        end
        ST_INIT: begin
          if (ms_tick) begin
            ms_left <= ms_left - 8'h1;
            if (ms_left == 8'h1) begin
              state <= ST_FRAME;
              bit_cnt <= 9'h1;
              tx_bit <= buf_bus.tx_rdata[7];
            end
          end
        end
        ST_FRAME: begin
          if (frame_end) begin
            bit_cnt <= 9'h0;
            tx_bit <= 1'b0;
            if (!last_frame) begin
              frame_cnt <= frame_cnt + 4'h1;
              if (base_timer_field != REG_RESET) begin
                state <= ST_GAP;
                ms_left <= base_timer_field;
              end else begin
                bit_cnt <= 9'h1;
                tx_bit <= buf_bus.tx_rdata[7];
              end
            end else if (end_of_message_pad) begin
              state <= ST_EOM;
              eom_cnt <= 2'h0;
              tx_bit <= 1'b1;
            end else if (interframe_interrupt_delay && base_timer_field != REG_RESET) begin
              state <= ST_TAIL;
              ms_left <= base_timer_field;
            end else begin
              state <= ST_IDLE;
              done <= 1'b1;
            end
          end else if (bit_tick) begin
            // MSB of each byte goes out first
            tx_bit <= buf_bus.tx_rdata[3'h7 - bit_cnt[2:0]];
            bit_cnt <= bit_cnt + 9'h1;
          end
        end
        ST_EOM: begin
          if (bit_tick) begin
            eom_cnt <= eom_cnt + 2'h1;
            if (eom_cnt == EOM_BIT_TIMES - 2'h1) begin
              tx_bit <= 1'b0;
              if (interframe_interrupt_delay && base_timer_field != REG_RESET) begin
                state <= ST_TAIL;
                ms_left <= base_timer_field;
              end else begin
                state <= ST_IDLE;
                done <= 1'b1;
              end
            end
          end
        end
        ST_GAP: begin
          if (ms_tick) begin
            ms_left <= ms_left - 8'h1;
            if (ms_left == 8'h1) begin
              state <= ST_FRAME;
              bit_cnt <= 9'h1;
              tx_bit <= buf_bus.tx_rdata[7];
            end
          end
        end
        ST_TAIL: begin
          if (ms_tick) begin
            ms_left <= ms_left - 8'h1;
            if (ms_left == 8'h1) begin
              state <= ST_IDLE;
              done <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // RF stage control
  // ----------------------------------------------------------------
  logic direct_mode;
  logic gap_power_down;

  assign direct_mode = (output_mode == MODE_DIRECT);
  // The tail interval has no following frame, so it never restarts early
  assign gap_power_down = interframe_power_down
    && ((state == ST_GAP && ms_left > RESTART_LEAD_MS) || state == ST_TAIL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_data_out <= 1'b0;
      pa_enable <= 1'b0;
      osc_enable <= 1'b0;
    end else begin
      rf_data_out <= direct_mode ? direct_data : tx_bit;
      pa_enable <= direct_mode ? send : (state == ST_FRAME || state == ST_EOM);
      osc_enable <= send && !gap_power_down;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite && mapped) begin
      if (is_buf) begin
        prdata[7:0] = buf_bus.bus_rdata;
      end else if (is_bank) begin
        prdata[7:0] = bank[bank_sel];
      end else begin
        case (idx)
          IDX_OUTPUT_MODE: prdata[1:0] = output_mode;
          IDX_FRAME_BIT_LENGTH: prdata[7:0] = frame_length_field;
          IDX_TRANSMIT_START: prdata[7:0] = {send, buffer_page_select, end_of_message_pad, 5'h0};
          IDX_FRAME_COUNT: prdata[7:0] = frame_count_and_spacing_control;
          IDX_BASE_TIMER: prdata[7:0] = base_timer_field;
          IDX_STATUS_CONTROL: prdata[7:0] = {completion_flag, 3'h0, completion_interrupt_enable, 3'h0};
          default: prdata = 32'h0;
        endcase
      end
    end
  end

endmodule

/* File: dv/rfdf_top_checker.sv */
// Port assertions of the datagram frame control block
`timescale 1ns/100ps
module rfdf_top_checker
  import rfdf_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int BIT_TICK_CYCLES = BIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rf_data_out,
  input wire logic pa_enable,
  input wire logic osc_enable,
  input wire logic completion_irq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic acc;
  logic wr37;
  int pa_run;
  assign acc = psel && penable;
  assign wr37 = acc && pwrite && paddr[11:2] == 10'h037;
  // Counts amplifier-on cycles, so short frames show without long repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_run <= 0;
    end else begin
      pa_run <= pa_enable ? pa_run + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_const: assert property (acc |-> pready) else $error("pready low in access");
  a_err_unmapped: assert property (acc && paddr[11:2] == 10'h035 |-> pslverr) else $error("no error on hole");
  a_rdata_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
  a_rdata_err: assert property (acc && !pwrite && pslverr |-> prdata == 32'h00000000) else $error("error read not 0");
  a_osc_before_pa: assert property ($rose(pa_enable) |-> osc_enable) else $error("amp on, osc off");
  a_irq_hold: assert property (completion_irq && !wr37 && !$past(wr37) |=> completion_irq)
    else $error("flag dropped unacked");
  a_irq_ack: assert property (wr37 && pwdata[STAT_ACK_BIT] |-> ##2 !completion_irq) else $error("ack ignored");
  a_frame_min: assert property ($fell(pa_enable) |-> pa_run >= 2 * BIT_TICK_CYCLES)
    else $error("frame under two bits");
  a_reset_idle: assert property ($rose(presetn) |-> !pa_enable && !osc_enable && !completion_irq)
    else $error("outputs active after reset");
  c_frame: cover property ($fell(pa_enable));
  c_irq: cover property ($rose(completion_irq));
  c_err: cover property (acc && pslverr);
endmodule
bind rfdf_top rfdf_top_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES), .BIT_TICK_CYCLES(BIT_TICK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rf_data_out(rf_data_out),
  .pa_enable(pa_enable), .osc_enable(osc_enable), .completion_irq(completion_irq));

/* File: dv/rfdf_rf_stage_model.sv */
// Behavioural RF output stage: counts frames, amplifier time and power cycling
`timescale 1ns/100ps
module rfdf_rf_stage_model (
  input wire logic pclk,
  input wire logic rf_data_out,
  input wire logic pa_enable,
  input wire logic osc_enable,
  output int frames,
  output int pa_cyc,
  output int osc_drops,
  output int lead
);
  logic pa_q = 1'b0;
  logic osc_q = 1'b0;
  int since_osc = 0;
  // Pure sink: a real stage gives nothing back on these pins
  always @(posedge pclk) begin
    pa_q <= pa_enable;
    osc_q <= osc_enable;
    // The rising edge itself counts, so lead is the cycles the oscillator ran ahead
    since_osc <= (osc_enable && !osc_q) ? 1 : since_osc + 1;
    if (pa_enable && !pa_q) begin
      frames <= frames + 1;
      lead <= since_osc;
    end
    if (pa_enable) begin
      pa_cyc <= pa_cyc + 1;
    end
    if (!osc_enable && osc_q) begin
      osc_drops <= osc_drops + 1;
    end
  end
  initial begin
    frames = 0;
    pa_cyc = 0;
    osc_drops = 0;
    lead = 0;
  end
endmodule

/* File: dv/rf_datagram_frame_control_tb_top.sv */
// Self-checking bench of the datagram frame control block
`timescale 1ns/100ps
module rf_datagram_frame_control_tb_top;
  import rfdf_pkg::*;
  localparam int MS = 20;
  localparam int BT = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, rf_data_out, pa_enable, osc_enable, completion_irq;
  int frames, pa_cyc, osc_drops, lead;
  int fails = 0;
  int n_checks = 0;
  int df, dp, e0, e1, e2, e3, e4;
  logic [31:0] rd;
  logic er;
  always #25 pclk = ~pclk;
  rfdf_top #(.MS_TICK_CYCLES(MS), .BIT_TICK_CYCLES(BT)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rf_data_out(rf_data_out), .pa_enable(pa_enable), .osc_enable(osc_enable),
    .completion_irq(completion_irq));
  rfdf_rf_stage_model u_rf (.pclk(pclk), .rf_data_out(rf_data_out), .pa_enable(pa_enable),
    .osc_enable(osc_enable), .frames(frames), .pa_cyc(pa_cyc), .osc_drops(osc_drops), .lead(lead));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rchk(input logic [7:0] i, input logic [7:0] exp);
    apb(1'b0, i, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask
  // Sends, waits for the interrupt, acknowledges; cycles from send to interrupt
  task run(input logic [7:0] len, input logic [7:0] cfg, input logic [7:0] tx, output int cyc);
    int f, p;
    f = frames;
    p = pa_cyc;
    apb(1'b1, IDX_FRAME_BIT_LENGTH, len);
    apb(1'b1, IDX_FRAME_COUNT, cfg);
    apb(1'b1, IDX_TRANSMIT_START, tx);
    cyc = 0;
    while (completion_irq !== 1'b1 && cyc < 4000) begin
      @(posedge pclk);
      cyc++;
    end
    chk(completion_irq, 1'b1);
    rchk(IDX_TRANSMIT_START, tx & 8'h7F);
    apb(1'b1, IDX_STATUS_CONTROL, 8'h18);
    repeat (3) @(posedge pclk);
    chk(completion_irq, 1'b0);
    df = frames - f;
    dp = pa_cyc - p;
  endtask
  task stop_test;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rchk(IDX_FRAME_BIT_LENGTH, 8'h00);
    rchk(IDX_TRANSMIT_START, 8'h00);
    rchk(IDX_FRAME_COUNT, 8'h00);
    apb(1'b0, 8'h35, 8'h00);
    chk({rd[7:0], 7'h00, er}, 16'h0001);
  endtask
  task t_page;
    apb(1'b1, IDX_TRANSMIT_START, 8'h40);
    apb(1'b1, IDX_BUF_FIRST, 8'h5A);
    apb(1'b1, IDX_BANK_FIRST, 8'h11);
    apb(1'b1, IDX_TRANSMIT_START, 8'h00);
    apb(1'b1, IDX_BUF_FIRST, 8'h3C);
    apb(1'b1, IDX_BANK_FIRST, 8'h22);
    rchk(IDX_BUF_FIRST, 8'h3C);
    rchk(IDX_BANK_FIRST, 8'h22);
    apb(1'b1, IDX_TRANSMIT_START, 8'h60);
    rchk(IDX_BUF_FIRST, 8'h5A);
    rchk(IDX_BANK_FIRST, 8'h11);
    apb(1'b1, IDX_FRAME_BIT_LENGTH, 8'h77);
    apb(1'b1, IDX_FRAME_COUNT, 8'h5F);
    apb(1'b1, IDX_STATUS_CONTROL, 8'h01);
    repeat (2) @(posedge pclk);
    rchk(IDX_TRANSMIT_START, 8'h40);
    rchk(IDX_FRAME_BIT_LENGTH, 8'h00);
    rchk(IDX_FRAME_COUNT, 8'h00);
    rchk(IDX_BUF_FIRST, 8'h5A);
    apb(1'b1, IDX_TRANSMIT_START, 8'h00);
    apb(1'b1, IDX_STATUS_CONTROL, 8'h08);
  endtask
  task t_frames;
    apb(1'b1, IDX_BASE_TIMER, 8'h02);
    run(8'h01, 8'h00, 8'h80, e0);
    chk(dp, 2 * BT);
    run(8'h01, 8'h00, 8'hA0, e1);
    chk(dp, 4 * BT);
    run(8'h00, 8'h01, 8'h80, e1);
    chk(df, 0);
    run(8'h01, 8'h20, 8'h80, e1);
    chk(e1 - e0, 2 * MS);
    run(8'h03, 8'h01, 8'h80, e2);
    chk(df, 2);
    chk(dp, 8 * BT);
    run(8'h03, 8'h11, 8'h80, e3);
    chk(e3 - e2, 2 * MS);
    apb(1'b1, IDX_BASE_TIMER, 8'h00);
    run(8'h03, 8'h01, 8'h80, e4);
    chk(e2 - e4, 2 * MS);
  endtask
  task t_powerdown;
    int d;
    d = osc_drops;
    apb(1'b1, IDX_BASE_TIMER, 8'h03);
    run(8'h03, 8'h41, 8'h80, e0);
    chk(osc_drops - d >= 2, 1'b1);
    chk(lead, MS);
  endtask
  task t_abort;
    apb(1'b1, IDX_FRAME_BIT_LENGTH, 8'hFF);
    apb(1'b1, IDX_TRANSMIT_START, 8'h80);
    repeat (40) @(posedge pclk);
    apb(1'b1, IDX_TRANSMIT_START, 8'h00);
    repeat (4) @(posedge pclk);
    chk({pa_enable, completion_irq}, 2'b00);
  endtask
  task t_direct;
    apb(1'b1, IDX_OUTPUT_MODE, 8'h03);
    apb(1'b1, IDX_FRAME_COUNT, 8'h80);
    apb(1'b1, IDX_TRANSMIT_START, 8'h80);
    repeat (4) @(posedge pclk);
    chk({pa_enable, rf_data_out}, 2'b11);
    apb(1'b1, IDX_FRAME_COUNT, 8'h00);
    repeat (4) @(posedge pclk);
    chk(rf_data_out, 1'b0);
    apb(1'b1, IDX_TRANSMIT_START, 8'h00);
    apb(1'b1, IDX_OUTPUT_MODE, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_page();
    t_frames();
    t_powerdown();
    t_abort();
    t_direct();
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    stop_test();
  end
endmodule
